// [inc/sfs_pkg.sv]
// constants and types of the fail-safe / development / cyclic-sense mode logic
package sfs_pkg;
    localparam int CLK_HZ = 50_000_000;
    // wake filter, restart, reset and glitch times in microseconds
    localparam int FS_WAKE_FILTER_US = 100_000;
    localparam int TSD_RESTART_US = 1_000_000;
    localparam int WAKE_FILTER_US = 16;
    localparam int RESET_DELAY_US = 10;
    localparam int TEST_GLITCH_US = 10;
    localparam int FS_WAKE_FILTER_CYC = FS_WAKE_FILTER_US * (CLK_HZ / 1_000_000);
    localparam int TSD_RESTART_CYC = TSD_RESTART_US * (CLK_HZ / 1_000_000);
    localparam int WAKE_FILTER_CYC = WAKE_FILTER_US * (CLK_HZ / 1_000_000);
    localparam int RESET_DELAY_CYC = RESET_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int TEST_GLITCH_CYC = TEST_GLITCH_US * (CLK_HZ / 1_000_000);
    localparam int UV_FS_COUNT = 4;
    // status field encodings
    localparam logic [1:0] DEVICE_STATUS_FIELD_CLEAR = 2'h0;
    localparam logic [1:0] DEVICE_STATUS_FIELD_FAIL = 2'h1;
    localparam logic [1:0] DEVICE_STATUS_FIELD_SLEEP = 2'h2;
    localparam logic [1:0] WATCHDOG_FAIL_COUNT_ONE = 2'h1;
    localparam logic [1:0] WATCHDOG_FAIL_COUNT_TWO = 2'h2;
    localparam logic PCFG_FAILSAFE = 1'b0;
    localparam logic PCFG_RESTART = 1'b1;
    localparam int NUM_WAKE = 3;
    localparam int NUM_FAIL_OUT = 3;
    localparam int NUM_TIMER = 2;
    // modes, one-hot
    typedef enum logic [5:0] {
        SFS_INIT = 6'h01,
        SFS_NORMAL = 6'h02,
        SFS_STOP = 6'h04,
        SFS_SLEEP = 6'h08,
        SFS_RESTART = 6'h10,
        SFS_FAILSAFE = 6'h20
    } sfs_mode_t;
    typedef enum logic [1:0] {
        SFS_REQ_NONE = 2'h0,
        SFS_REQ_NORMAL = 2'h1,
        SFS_REQ_STOP = 2'h2,
        SFS_REQ_SLEEP = 2'h3
    } sfs_req_t;
endpackage

// [logic/sfs_mode_ctrl.sv]
// mode state machine: fail-safe, development mode and cyclic-sense wake detection
module sfs_mode_ctrl #(
    parameter int FS_FILTER_CYC = sfs_pkg::FS_WAKE_FILTER_CYC,
    parameter int TSD_CYC = sfs_pkg::TSD_RESTART_CYC,
    parameter int PERIOD_W = 24
) (
    // clock and power-on reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // controller requests and configuration
    input wire sfs_pkg::sfs_req_t mode_req_in,
    input wire logic spi_cmd_in,
    input wire logic overvoltage_reset_enable_in,
    input wire logic product_config_select_in,
    input wire logic config_four_in,
    input wire logic wake_measure_select_in,
    input wire logic [sfs_pkg::NUM_WAKE-1:0] wake_enable_in,
    input wire logic status_clear_in,
    input wire logic [sfs_pkg::NUM_TIMER-1:0] timer_start_in,
    input wire logic [PERIOD_W-1:0] timer_one_period_in,
    input wire logic [PERIOD_W-1:0] timer_one_on_in,
    input wire logic [PERIOD_W-1:0] timer_two_period_in,
    input wire logic [PERIOD_W-1:0] timer_two_on_in,
    input wire logic [sfs_pkg::NUM_WAKE-1:0] wake_timer_map_in,
    // monitors and pins
    input wire logic thermal_shutdown_level_two_in,
    input wire logic main_overvoltage_in,
    input wire logic main_short_in,
    input wire logic main_undervoltage_in,
    input wire logic supply_good_in,
    input wire logic watchdog_fail_in,
    input wire logic can_wake_in,
    input wire logic [sfs_pkg::NUM_WAKE-1:0] wake_input_in,
    input wire logic fail_output_test_pin_in,
    // outputs and status
    output logic [5:0] mode_out,
    output logic reset_n_out,
    output logic int_n_out,
    output logic main_regulator_on_out,
    output logic auxiliary_regulator_on_out,
    output logic external_pass_regulator_on_out,
    output logic can_on_out,
    output logic can_wake_capable_out,
    output logic drivers_on_out,
    output logic [sfs_pkg::NUM_TIMER-1:0] high_side_switch_out,
    output logic [sfs_pkg::NUM_FAIL_OUT-1:0] fail_output_out,
    output logic development_mode_out,
    output logic watchdog_run_out,
    output logic cyclic_sense_on_out,
    output logic [sfs_pkg::NUM_WAKE-1:0] wake_source_on_out,
    output logic [1:0] device_status_field_out,
    output logic failure_flag_out,
    output logic spi_fail_flag_out,
    output logic [1:0] watchdog_fail_count_out,
    output logic thermal_flag_out,
    output logic main_undervoltage_flag_out,
    output logic main_undervoltage_failsafe_flag_out,
    output logic main_overvoltage_flag_out,
    output logic main_short_flag_out,
    output logic [sfs_pkg::NUM_WAKE-1:0] wake_input_woken_flag_out,
    output logic can_woken_flag_out,
    output logic [sfs_pkg::NUM_WAKE-1:0] wake_level_status_out
);
    import sfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change counted when stages two and three agree
    logic [NUM_WAKE+3:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
    logic [NUM_WAKE+3:0] raw;
    assign raw = {fail_output_test_pin_in, can_wake_in, thermal_shutdown_level_two_in,
                  main_short_in, wake_input_in};
    always_comb begin
        pin_nxt = pin_r;
        for (int i = 0; i < NUM_WAKE + 4; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                pin_nxt[i] = s3_r[i];
            end
        end
    end
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= pin_nxt;
        end
    end
    logic [NUM_WAKE-1:0] wk;
    logic short_s, tsd_s, canwk_s, test_s;
    assign wk = pin_r[NUM_WAKE-1:0];
    assign short_s = pin_r[NUM_WAKE];
    assign tsd_s = pin_r[NUM_WAKE+1];
    assign canwk_s = pin_r[NUM_WAKE+2];
    assign test_s = pin_r[NUM_WAKE+3];

    ////////////////////////////////////////////////////////////////////////////
    // cyclic-sense timers and wake sampling
    logic [NUM_TIMER-1:0] trun_r, trun_nxt;
    logic [PERIOD_W-1:0] tcnt_r [NUM_TIMER], tcnt_nxt [NUM_TIMER];
    logic [PERIOD_W-1:0] per [NUM_TIMER], ont [NUM_TIMER];
    logic [NUM_TIMER-1:0] on_end;
    logic [NUM_WAKE-1:0] ref_r, ref_nxt, refv_r, refv_nxt;
    logic [NUM_WAKE-1:0] fil_r, fil_nxt, cs_wake;
    logic [NUM_WAKE-1:0] fval_r, fval_nxt;
    logic [15:0] fcnt_r [NUM_WAKE], fcnt_nxt [NUM_WAKE];
    logic cs_allow, ot_bad;
    assign per[0] = timer_one_period_in;
    assign per[1] = timer_two_period_in;
    assign ont[0] = timer_one_on_in;
    assign ont[1] = timer_two_on_in;
    assign ot_bad = (ont[0] > per[0]) || (ont[1] > per[1]);
    always_comb begin
        trun_nxt = trun_r;
        on_end = '0;
        for (int t = 0; t < NUM_TIMER; t++) begin
            tcnt_nxt[t] = tcnt_r[t];
            // start on on-time write; switch faults never stop it
            if (timer_start_in[t] && cs_allow) begin
                trun_nxt[t] = 1'b1;
                tcnt_nxt[t] = '0;
            end else if (!cs_allow) begin
                trun_nxt[t] = 1'b0;
            end else if (trun_r[t]) begin
                on_end[t] = (tcnt_r[t] == ont[t] - 1'b1);
                tcnt_nxt[t] = (tcnt_r[t] >= per[t] - 1'b1) ? '0 : tcnt_r[t] + 1'b1;
            end
        end
        ref_nxt = ref_r;
        refv_nxt = refv_r;
        fil_nxt = fil_r;
        fval_nxt = fval_r;
        cs_wake = '0;
        for (int w = 0; w < NUM_WAKE; w++) begin
            fcnt_nxt[w] = fcnt_r[w];
            if (!cs_allow) begin
                fil_nxt[w] = 1'b0;
                refv_nxt[w] = 1'b0;
            end else if (on_end[wake_timer_map_in[w]]) begin
                fil_nxt[w] = 1'b1; // filter starts at end of on-time
                fval_nxt[w] = wk[w];
                fcnt_nxt[w] = '0;
            end else if (fil_r[w]) begin
                if (wk[w] != fval_r[w]) begin
                    fil_nxt[w] = 1'b0; // level crossed, sample dropped
                end else if (fcnt_r[w] == 16'(WAKE_FILTER_CYC - 1)) begin
                    fil_nxt[w] = 1'b0;
                    ref_nxt[w] = fval_r[w];
                    refv_nxt[w] = 1'b1; // first sample only sets reference
                    cs_wake[w] = refv_r[w] && (fval_r[w] != ref_r[w]) && wake_enable_in[w];
                end else begin
                    fcnt_nxt[w] = fcnt_r[w] + 16'h0001;
                end
            end
        end
    end
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            trun_r <= '0;
            ref_r <= '0;
            refv_r <= '0;
            fil_r <= '0;
            fval_r <= '0;
            for (int t = 0; t < NUM_TIMER; t++) tcnt_r[t] <= '0;
            for (int w = 0; w < NUM_WAKE; w++) fcnt_r[w] <= '0;
        end else begin
            trun_r <= trun_nxt;
            ref_r <= ref_nxt;
            refv_r <= refv_nxt;
            fil_r <= fil_nxt;
            fval_r <= fval_nxt;
            tcnt_r <= tcnt_nxt;
            fcnt_r <= fcnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode machine, power-on reset only
    sfs_mode_t mode_r, mode_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic tsd_fs_r, tsd_fs_nxt, pend_r, pend_nxt, dev_r, dev_nxt;
    logic [31:0] tst_r, tst_nxt;
    logic tst_bad_r, tst_bad_nxt, wdf2_r, wdf2_nxt;
    logic [2:0] uv_r, uv_nxt;
    logic uv_d_r, uv_d_nxt;
    logic [NUM_FAIL_OUT-1:0] fo_r, fo_nxt;
    logic [NUM_WAKE-1:0] wsrc_r, wsrc_nxt, woke_r, woke_nxt, lvl_r, lvl_nxt;
    logic [1:0] dst_r, dst_nxt, wdc_r, wdc_nxt;
    logic fail_r, fail_nxt, spif_r, spif_nxt, tf_r, tf_nxt, canw_r, canw_nxt;
    logic uvf_r, uvf_nxt, uvfs_r, uvfs_nxt, ovf_r, ovf_nxt, scf_r, scf_nxt;
    logic rst_n_r, rst_n_nxt, int_n_r, int_n_nxt;
    logic go_fs, go_rst, wd_fs, wd_rst, uv_rise, wake_ev, lowpwr;
    assign cs_allow = (mode_r != SFS_FAILSAFE);
    assign lowpwr = (mode_r == SFS_SLEEP) || (mode_r == SFS_FAILSAFE);
    assign uv_rise = main_undervoltage_in && !uv_d_r;
    // development mode masks every watchdog failure
    assign wd_fs = watchdog_fail_in && !dev_r && (!config_four_in || wdf2_r);
    assign wd_rst = watchdog_fail_in && !dev_r && !wd_fs;
    assign go_fs = tsd_s
        || (main_overvoltage_in && overvoltage_reset_enable_in
            && product_config_select_in == PCFG_FAILSAFE)
        || wd_fs || short_s
        || (uv_rise && supply_good_in && uv_r == 3'(UV_FS_COUNT - 1));
    assign go_rst = (main_overvoltage_in && overvoltage_reset_enable_in
            && product_config_select_in == PCFG_RESTART) || wd_rst
        || (uv_rise && (mode_r == SFS_NORMAL || mode_r == SFS_STOP));
    assign wake_ev = |cs_wake || (canwk_s && lowpwr) || (|(wk & wsrc_r) && lowpwr);
    always_comb begin
        mode_nxt = mode_r;
        cnt_nxt = cnt_r;
        tsd_fs_nxt = tsd_fs_r;
        pend_nxt = pend_r;
        dev_nxt = dev_r;
        tst_nxt = tst_r;
        tst_bad_nxt = tst_bad_r;
        wdf2_nxt = wdf2_r;
        uv_d_nxt = main_undervoltage_in;
        uv_nxt = uv_r;
        fo_nxt = fo_r;
        wsrc_nxt = wsrc_r;
        woke_nxt = woke_r | cs_wake; // set wins over clear
        lvl_nxt = lvl_r;
        dst_nxt = dst_r;
        wdc_nxt = wdc_r;
        fail_nxt = fail_r;
        spif_nxt = spif_r || ot_bad;
        tf_nxt = tf_r;
        canw_nxt = canw_r || (canwk_s && lowpwr);
        uvf_nxt = uvf_r;
        uvfs_nxt = uvfs_r;
        ovf_nxt = ovf_r || main_overvoltage_in;
        scf_nxt = scf_r;
        rst_n_nxt = rst_n_r;
        int_n_nxt = 1'b1;
        if (status_clear_in) begin
            woke_nxt = cs_wake;
            canw_nxt = canwk_s && lowpwr;
            spif_nxt = ot_bad;
            fail_nxt = 1'b0;
            dst_nxt = DEVICE_STATUS_FIELD_CLEAR;
            wdc_nxt = '0;
            tf_nxt = 1'b0;
            uvf_nxt = 1'b0;
            uvfs_nxt = 1'b0;
            ovf_nxt = main_overvoltage_in;
            scf_nxt = 1'b0;
        end
        if (uv_rise) begin
            uv_nxt = (uv_r == 3'(UV_FS_COUNT - 1)) ? '0 : uv_r + 3'h1;
            uvf_nxt = 1'b1;
        end
        if (watchdog_fail_in && !dev_r) begin
            wdf2_nxt = 1'b1;
            wdc_nxt = wdf2_r ? WATCHDOG_FAIL_COUNT_TWO : WATCHDOG_FAIL_COUNT_ONE;
        end
        if ((mode_r == SFS_NORMAL || mode_r == SFS_STOP) && |cs_wake) begin
            int_n_nxt = 1'b0;
        end
        if (mode_r == SFS_NORMAL || mode_r == SFS_STOP) begin
            for (int w = 0; w < NUM_WAKE; w++) begin
                if (fil_r[w] && wk[w] == fval_r[w] && fcnt_r[w] == 16'(WAKE_FILTER_CYC - 1)) begin
                    lvl_nxt[w] = fval_r[w];
                end
            end
        end
        if (mode_r != SFS_FAILSAFE && go_fs) begin
            mode_nxt = SFS_FAILSAFE;
            cnt_nxt = '0;
            pend_nxt = 1'b0;
            tsd_fs_nxt = tsd_s;
            fo_nxt = '1;
            // measurement-function inputs stay out of the wake sources
            wsrc_nxt = wake_measure_select_in ? {1'b1, 2'b00} : '1;
            woke_nxt = '0;
            canw_nxt = 1'b0;
            fail_nxt = 1'b1;
            dst_nxt = DEVICE_STATUS_FIELD_FAIL;
            tf_nxt = tf_r || tsd_s;
            scf_nxt = scf_r || short_s;
            uvf_nxt = uvf_r || short_s || uv_rise;
            uvfs_nxt = uvfs_r || (uv_rise && !short_s && !tsd_s);
            rst_n_nxt = 1'b0;
        end else if (mode_r != SFS_FAILSAFE && mode_r != SFS_INIT && go_rst) begin
            mode_nxt = SFS_RESTART;
            cnt_nxt = '0;
            dst_nxt = DEVICE_STATUS_FIELD_FAIL;
            fo_nxt = (wd_rst || main_overvoltage_in) ? '1 : fo_r;
            rst_n_nxt = 1'b0;
        end else begin
            case (mode_r)
                SFS_INIT: begin
                    if (test_s) begin
                        tst_nxt = tst_r + 32'h1;
                        if (tst_r >= 32'(TEST_GLITCH_CYC)) tst_bad_nxt = 1'b1;
                    end else begin
                        tst_nxt = '0;
                    end
                    if (spi_cmd_in) begin
                        dev_nxt = !test_s && !tst_bad_r;
                        mode_nxt = SFS_NORMAL;
                    end
                end
                SFS_NORMAL: begin
                    if (mode_req_in == SFS_REQ_STOP) mode_nxt = SFS_STOP;
                    if (mode_req_in == SFS_REQ_SLEEP) begin
                        // uncleared wake flags bounce straight back via restart
                        if (|woke_r || canw_r) begin
                            mode_nxt = SFS_RESTART;
                            cnt_nxt = '0;
                            rst_n_nxt = 1'b0;
                        end else begin
                            mode_nxt = SFS_SLEEP;
                            dst_nxt = DEVICE_STATUS_FIELD_SLEEP;
                        end
                    end
                end
                SFS_STOP: begin
                    if (mode_req_in == SFS_REQ_NORMAL) mode_nxt = SFS_NORMAL;
                end
                SFS_SLEEP: begin
                    if (wake_ev) begin
                        mode_nxt = SFS_RESTART;
                        cnt_nxt = '0;
                        rst_n_nxt = 1'b0;
                    end
                end
                SFS_RESTART: begin
                    cnt_nxt = cnt_r + 32'h1;
                    if (cnt_r >= 32'(RESET_DELAY_CYC - 1)) begin
                        mode_nxt = SFS_NORMAL;
                        rst_n_nxt = 1'b1;
                    end
                end
                SFS_FAILSAFE: begin
                    cnt_nxt = cnt_r + 32'h1;
                    pend_nxt = pend_r || wake_ev; // stored during filter
                    if (tsd_fs_r ? (cnt_r >= 32'(TSD_CYC - 1))
                                 : ((pend_r || wake_ev)
                                    && cnt_r >= 32'(FS_FILTER_CYC - 1))) begin
                        mode_nxt = SFS_RESTART;
                        cnt_nxt = '0;
                        woke_nxt = woke_r | (wk & wsrc_r);
                    end
                end
                default: mode_nxt = SFS_INIT;
            endcase
        end
    end
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_r <= SFS_INIT;
            cnt_r <= '0;
            tsd_fs_r <= 1'b0;
            pend_r <= 1'b0;
            dev_r <= 1'b0; // cleared by power-on only
            tst_r <= '0;
            tst_bad_r <= 1'b0;
            wdf2_r <= 1'b0;
            uv_r <= '0;
            uv_d_r <= 1'b0;
            fo_r <= '0;
            wsrc_r <= '1;
            woke_r <= '0;
            lvl_r <= '0;
            dst_r <= DEVICE_STATUS_FIELD_CLEAR;
            wdc_r <= '0;
            fail_r <= 1'b0;
            spif_r <= 1'b0;
            tf_r <= 1'b0;
            canw_r <= 1'b0;
            uvf_r <= 1'b0;
            uvfs_r <= 1'b0;
            ovf_r <= 1'b0;
            scf_r <= 1'b0;
            rst_n_r <= 1'b0;
            int_n_r <= 1'b1;
        end else begin
            mode_r <= mode_nxt;
            cnt_r <= cnt_nxt;
            tsd_fs_r <= tsd_fs_nxt;
            pend_r <= pend_nxt;
            dev_r <= dev_nxt;
            tst_r <= tst_nxt;
            tst_bad_r <= tst_bad_nxt;
            wdf2_r <= wdf2_nxt;
            uv_r <= uv_nxt;
            uv_d_r <= uv_d_nxt;
            fo_r <= fo_nxt;
            wsrc_r <= wsrc_nxt;
            woke_r <= woke_nxt;
            lvl_r <= lvl_nxt;
            dst_r <= dst_nxt;
            wdc_r <= wdc_nxt;
            fail_r <= fail_nxt;
            spif_r <= spif_nxt;
            tf_r <= tf_nxt;
            canw_r <= canw_nxt;
            uvf_r <= uvf_nxt;
            uvfs_r <= uvfs_nxt;
            ovf_r <= ovf_nxt;
            scf_r <= scf_nxt;
            rst_n_r <= rst_n_nxt;
            int_n_r <= int_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs; supplies, CAN, drivers and watchdog off in fail-safe, timer switches in step with their counters, CAN wake capability on
    logic dev_on;
    // next value, so in development mode the auxiliary supply and CAN come up on the very edge that leaves init
    assign dev_on = dev_nxt && (mode_nxt == SFS_INIT || mode_nxt == SFS_NORMAL);
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_out <= SFS_INIT;
            main_regulator_on_out <= 1'b1;
            auxiliary_regulator_on_out <= 1'b0;
            external_pass_regulator_on_out <= 1'b0;
            can_on_out <= 1'b0;
            can_wake_capable_out <= 1'b0;
            drivers_on_out <= 1'b0;
            high_side_switch_out <= '0;
            watchdog_run_out <= 1'b0;
            cyclic_sense_on_out <= 1'b0;
            development_mode_out <= 1'b0;
        end else begin
            mode_out <= mode_nxt;
            main_regulator_on_out <= mode_nxt != SFS_FAILSAFE && mode_nxt != SFS_SLEEP;
            auxiliary_regulator_on_out <= dev_on;
            external_pass_regulator_on_out <= mode_nxt != SFS_FAILSAFE;
            can_on_out <= dev_on;
            can_wake_capable_out <= mode_nxt == SFS_FAILSAFE || mode_nxt == SFS_SLEEP;
            drivers_on_out <= mode_nxt != SFS_FAILSAFE && mode_nxt != SFS_RESTART;
            for (int t = 0; t < NUM_TIMER; t++) begin
                high_side_switch_out[t] <= trun_nxt[t] && (tcnt_nxt[t] < ont[t]);
            end
            watchdog_run_out <= !dev_r && mode_nxt == SFS_NORMAL;
            cyclic_sense_on_out <= |trun_nxt;
            development_mode_out <= dev_nxt;
        end
    end
    assign reset_n_out = rst_n_r;
    assign int_n_out = int_n_r;
    assign fail_output_out = fo_r;
    assign wake_source_on_out = wsrc_r;
    assign device_status_field_out = dst_r;
    assign failure_flag_out = fail_r;
    assign spi_fail_flag_out = spif_r;
    assign watchdog_fail_count_out = wdc_r;
    assign thermal_flag_out = tf_r;
    assign main_undervoltage_flag_out = uvf_r;
    assign main_undervoltage_failsafe_flag_out = uvfs_r;
    assign main_overvoltage_flag_out = ovf_r;
    assign main_short_flag_out = scf_r;
    assign wake_input_woken_flag_out = woke_r;
    assign can_woken_flag_out = canw_r;
    assign wake_level_status_out = lvl_r;
endmodule // sfs_mode_ctrl

// [sim/sfs_mode_ctrl_chk.sv]
// port checks of the mode logic
module sfs_chk (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [5:0] mode_out,
    input wire logic reset_n_out,
    input wire logic main_regulator_on_out,
    input wire logic drivers_on_out,
    input wire logic [2:0] fail_output_out,
    input wire logic failure_flag_out,
    input wire logic int_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    wire fs = mode_out == 6'h20;
    wire rs = mode_out == 6'h10;
    wire in_run = mode_out == 6'h02 || mode_out == 6'h04;
    // 8 cycles is far below both real dwells, so a short sim value still holds
    sequence rs_dwell;
        rs [*8];
    endsequence
    sequence fs_dwell;
        fs [*8];
    endsequence
    fs_fail_out_a: assert property (fs |-> fail_output_out == 3'h7)
        else $error("fail outputs off in fail-safe");
    fo_sticky_a: assert property (fail_output_out == 3'h7 |=> fail_output_out == 3'h7)
        else $error("fail outputs dropped");
    fs_power_off_a: assert property (fs |-> !main_regulator_on_out && !drivers_on_out)
        else $error("supply or drivers on in fail-safe");
    fs_flag_a: assert property ($rose(fs) |-> failure_flag_out)
        else $error("failure flag not set");
    fs_hold_a: assert property ($rose(fs) |-> fs_dwell)
        else $error("fail-safe left before filter");
    rs_reset_a: assert property (rs |-> !reset_n_out)
        else $error("reset released in restart");
    rs_hold_a: assert property ($rose(rs) |-> rs_dwell)
        else $error("restart too short");
    rs_exit_a: assert property ($fell(rs) |-> mode_out == 6'h02 && reset_n_out)
        else $error("restart not left to normal");
    int_pulse_a: assert property (!int_n_out |-> in_run ##1 int_n_out)
        else $error("interrupt pulse wrong");
endmodule // sfs_chk

// [sim/sfs_wake_model.sv]
// far-side model: wake switch contacts and the test-pin strap
module sfs_wake_model (
    input wire logic clk_in,
    input wire logic [2:0] level_in,
    input wire logic dev_req_in,
    output logic [2:0] wake_out,
    output logic test_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // contacts settle one edge after the bench moves them
    always_ff @(posedge clk_in) begin
        wake_out <= level_in;
    end
    assign test_pin_out = !dev_req_in; // strap low through init only when asked
endmodule // sfs_wake_model

// [sim/tb_sfs_mode_ctrl.sv]
// self-checking bench of the mode logic
bind sfs_mode_ctrl sfs_chk u_chk (.*);
module tb_sfs_mode_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import sfs_pkg::*;
    sfs_req_t mode_req_in = SFS_REQ_NONE;
    logic core_clk_in = 0, reset_in = 1, spi_cmd_in = 0, status_clear_in = 0, can_wake_in = 0;
    logic overvoltage_reset_enable_in = 0, product_config_select_in = 0, config_four_in = 0;
    logic wake_measure_select_in = 0, thermal_shutdown_level_two_in = 0, main_overvoltage_in = 0;
    logic main_short_in = 0, main_undervoltage_in = 0, supply_good_in = 1, watchdog_fail_in = 0;
    logic dev = 0, fail_output_test_pin_in;
    logic [2:0] wake_enable_in = 0, wake_timer_map_in = 0, lvl = 0, wake_input_in, fail_output_out;
    logic [2:0] wake_source_on_out, wake_input_woken_flag_out, wake_level_status_out;
    logic [1:0] timer_start_in = 0, high_side_switch_out, device_status_field_out;
    logic [1:0] watchdog_fail_count_out;
    logic [23:0] timer_one_period_in = 0, timer_one_on_in = 0;
    logic [23:0] timer_two_period_in = 0, timer_two_on_in = 0;
    logic [5:0] mode_out;
    logic reset_n_out, int_n_out, main_regulator_on_out, auxiliary_regulator_on_out, can_on_out;
    logic external_pass_regulator_on_out, can_wake_capable_out, drivers_on_out, thermal_flag_out;
    logic development_mode_out, watchdog_run_out, cyclic_sense_on_out, failure_flag_out;
    logic spi_fail_flag_out, main_undervoltage_flag_out, main_undervoltage_failsafe_flag_out;
    logic main_overvoltage_flag_out, main_short_flag_out, can_woken_flag_out;
    int miscompares = 0, total_checks = 0;
    sfs_mode_ctrl #(.FS_FILTER_CYC(200), .TSD_CYC(400)) DUT (.*);
    sfs_wake_model u_far (.clk_in(core_clk_in), .level_in(lvl), .dev_req_in(dev),
        .wake_out(wake_input_in), .test_pin_out(fail_output_test_pin_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(string what, logic [5:0] exp, logic [5:0] got);
        total_checks++;
        if (exp !== got) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic till(logic [5:0] m, int lim);
        repeat (lim) if (mode_out !== m) @(negedge core_clk_in);
        chk("mode", m, mode_out);
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // pins pass a synchroniser, so strap and spi wait some edges after reset
    task automatic boot(logic d);
        dev = d;
        reset_in = 1;
        repeat (6) @(negedge core_clk_in);
        reset_in = 0;
        chk("init", SFS_INIT, mode_out);
        repeat (8) @(negedge core_clk_in);
        spi_cmd_in = 1;
        @(negedge core_clk_in);
        spi_cmd_in = 0;
        till(SFS_NORMAL, 20);
        chk("dev mode", 6'(d), 6'(development_mode_out));
    endtask
    task automatic trip(ref logic f, input logic [5:0] m, input logic wk);
        status_clear_in = 1;
        @(negedge core_clk_in);
        status_clear_in = 0;
        f = 1;
        till(m, 20);
        f = 0;
        lvl = {3{wk}};
        till(SFS_NORMAL, 1200);
        lvl = 0;
        chk("status", 6'h1, 6'(device_status_field_out));
        chk("fail out", 6'h7, 6'(fail_output_out));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial forever #10 core_clk_in = ~core_clk_in;
    initial begin
        #1_000_000;
        miscompares++;
        results;
    end
    initial begin
        boot(0);
        timer_one_period_in = 24'h3e8;
        timer_one_on_in = 24'h64;
        wake_enable_in = 3'h1;
        timer_start_in = 2'h1;
        @(negedge core_clk_in);
        timer_start_in = 2'h0;
        chk("switch", 6'h5, 6'({cyclic_sense_on_out, high_side_switch_out}));
        timer_two_on_in = 24'h1;
        @(negedge core_clk_in);
        timer_two_on_in = 24'h0;
        chk("spi fail", 6'h1, 6'(spi_fail_flag_out));
        // reference sample settles first, then the input moves
        repeat (950) @(negedge core_clk_in);
        lvl = 3'h1;
        repeat (1000) @(negedge core_clk_in);
        chk("woken", 6'h1, 6'(wake_input_woken_flag_out));
        chk("level", 6'h1, 6'(wake_level_status_out));
        mode_req_in = SFS_REQ_SLEEP;
        till(SFS_RESTART, 4);
        mode_req_in = SFS_REQ_NONE;
        till(SFS_NORMAL, 600);
        trip(main_short_in, SFS_FAILSAFE, 1);
        chk("short", 6'h3, 6'({main_short_flag_out, main_undervoltage_flag_out}));
        trip(thermal_shutdown_level_two_in, SFS_FAILSAFE, 0);
        chk("thermal", 6'h1, 6'(thermal_flag_out));
        overvoltage_reset_enable_in = 1;
        product_config_select_in = 1;
        trip(main_overvoltage_in, SFS_RESTART, 0);
        product_config_select_in = 0;
        trip(main_overvoltage_in, SFS_FAILSAFE, 1);
        trip(watchdog_fail_in, SFS_FAILSAFE, 1);
        chk("wd count", 6'h1, 6'(watchdog_fail_count_out));
        config_four_in = 1;
        trip(watchdog_fail_in, SFS_FAILSAFE, 1);
        chk("wd count two", 6'h2, 6'(watchdog_fail_count_out));
        boot(1);
        chk("can aux", 6'h3, 6'({can_on_out, auxiliary_regulator_on_out}));
        watchdog_fail_in = 1;
        @(negedge core_clk_in);
        watchdog_fail_in = 0;
        repeat (20) @(negedge core_clk_in);
        chk("dev wd", SFS_NORMAL, mode_out);
        results;
    end
endmodule // tb_sfs_mode_ctrl
